// ---- rtl/mpf_map.svh ----
// register offsets, field positions, reset values and timing counts for the pwm filter/chopper slice
// assumes a 40 MHz core clock and byte-wide registers on a plain strobe port
`ifndef MPF_MAP_SVH
`define MPF_MAP_SVH

// ==========================================================
// offsets
`define MPF_OFS_DFILT      4'h0
`define MPF_OFS_REFCHOP    4'h1
`define MPF_OFS_PWMCTL     4'h2
`define MPF_OFS_UPDPER     4'h3
`define MPF_OFS_PERIPHCTL  4'h4
`define MPF_OFS_STATUS     4'h5

// ==========================================================
// reset values
`define MPF_RST_DFILT      8'h0f
`define MPF_RST_REFCHOP    8'h00
`define MPF_RST_PWMCTL     8'h00
`define MPF_RST_UPDPER     8'h00

// ==========================================================
// field positions
`define MPF_REF_HST_BIT    7
`define MPF_REF_CL_BIT     6
`define MPF_REF_CSEL_BIT   5
`define MPF_PWM_8BIT_BIT   7
`define MPF_PWM_FDU_BIT    6
`define MPF_PWM_FDV_BIT    5
`define MPF_PWM_FDW_BIT    4
`define MPF_PWM_CMS_BIT    3
`define MPF_CTL_CKE_BIT    0
`define MPF_CTL_SENS_BIT   1
`define MPF_CTL_SCF_LSB    2

// ==========================================================
// timing: blanking steps, nominal 4 MHz periph clock scaled to core clock
`define MPF_CLK_MHZ        40
`define MPF_BLANK_FINE_US  5
`define MPF_BLANK_COARSE_US 20
`define MPF_BLANK_FINE_CYC   (`MPF_BLANK_FINE_US * `MPF_CLK_MHZ)
`define MPF_BLANK_COARSE_CYC (`MPF_BLANK_COARSE_US * `MPF_CLK_MHZ)
// pwm period in prescaled ticks (16 bit compare, 13 active bits)
`define MPF_PWM_TOP        13'h1fff

`endif

// ---- rtl/mpf_pkg.sv ----
// types for the pwm filter/chopper slice
// assumes mpf_map.svh supplies the numeric constants
package mpf_pkg;
  typedef enum logic [1:0] {
    MPF_CHOP_OFF,
    MPF_CHOP_LOW,
    MPF_CHOP_HIGH,
    MPF_CHOP_BOTH
  } mpf_chop_t;

  typedef enum logic {
    MPF_CNT_UP,
    MPF_CNT_DOWN
  } mpf_dir_t;
endpackage

// ---- rtl/mpf_core.sv ----
// pwm counter, update pacing, chopper, d event filter and comparator status
// assumes comparator pins asynchronous, bus on core clock, d/c events from the same clock
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "mpf_map.svh"
`default_nettype none

// Operation
// - filtered d event needs field plus one consecutive valid samples, 1 to 16
// - d filter samples taken on selected sampling clock tick, every one to eight clocks
// - blank d detection after c event: 5us steps to 40us, then 20us steps
// - sensor mode applies no blanking window after c event
// - sensor select zero means sensorless, one means sensor mode
// - hysteresis comparator output readable as status bit 7
// - current loop comparator output readable as status bit 6
// - current input select picks amplifier output at 0, direct pin at 1
// - chop mode: off, low only, high only, both
// - three bit chop rate selects eight chopper frequencies
// - chopper output has fifty percent duty
// - standard mode uses compare b15:b3; eight-bit mode b14:b8 with the full-duty bit as top compare bit
// - full-duty bit forces 100% duty for one update period, then clears
// - counter edge aligned at 0, center aligned at 1
// - pwm counter clock is core clock divided by prescale plus one
// - down counter at zero: transfer compares, pulse update, reload
// - enabling peripheral clock forces repetition load and an update
// - new repetition value used only after next update
// - updates every n+1 periods edge, n+1 half periods center
module mpf_core (
  input  wire logic        core_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [7:0]  rdata_out,
  input  wire logic [15:0] phase_compare_u_in,
  input  wire logic [15:0] phase_compare_v_in,
  input  wire logic [15:0] phase_compare_w_in,
  input  wire logic        d_raw_in,
  input  wire logic        c_event_in,
  input  wire logic        hyst_comp_in,
  input  wire logic        amplifier_output_in,
  input  wire logic        direct_current_input_in,
  input  wire logic        cur_ref_comp_in,
  output logic             d_event_out,
  output logic             cur_comp_in_out,
  output logic             chop_high_out,
  output logic             chop_low_out,
  output logic [2:0]       pwm_out,
  output logic             update_out
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0]  dfilt;
    logic [7:0]  refchop;
    logic [7:0]  pwmctl;
    logic [7:0]  updper;
    logic [7:0]  periph;
    logic [7:0]  rdata;
    logic [1:0]  hst_s;
    logic [1:0]  cl_s;
    logic [1:0]  dr_s;
    logic [1:0]  amp_s;
    logic [1:0]  dci_s;
    logic [4:0]  dcnt;
    logic        dev;
    logic [13:0] blank;
    logic [7:0]  scf_div;
    logic [7:0]  chop_div;
    logic        chop_ph;
    logic [2:0]  pre;
    logic [12:0] cnt;
    mpf_pkg::mpf_dir_t dir;
    logic [7:0]  rep_act;
    logic [7:0]  rep_cnt;
    logic [2:0]  full_act;
    logic [38:0] cmp_act;
    logic        upd;
    logic [2:0]  pwm;
    logic        cur_sel;
    logic        chh;
    logic        chl;
  } mpf_state_t;

  mpf_state_t s_q;
  mpf_state_t s_d;

  // chopper half period in core cycles (40 MHz ref: 100k..2M)
  function automatic logic [7:0] chop_half(input logic [2:0] code);
    case (code)
      3'h0:    chop_half = 8'hc8;
      3'h1:    chop_half = 8'h64;
      3'h2:    chop_half = 8'h32;
      3'h3:    chop_half = 8'h28;
      3'h4:    chop_half = 8'h19;
      3'h5:    chop_half = 8'h14;
      3'h6:    chop_half = 8'h0f;
      default: chop_half = 8'h0a;
    endcase
  endfunction

  function automatic logic [12:0] cmp_of(input logic [12:0] raw, input logic eight, input logic ext);
    if (eight) begin
      cmp_of = {ext, raw[11:5], 5'h00};
    end else begin
      cmp_of = raw;
    end
  endfunction

  logic [13:0] blank_len;
  logic        sample_tick;
  logic        cnt_tick;
  logic        period_edge;
  logic [12:0] cmp_u;
  logic [12:0] cmp_v;
  logic [12:0] cmp_w;

  always_comb begin
    s_d = s_q;
    blank_len = 14'h0000;
    sample_tick = 1'b0;
    cnt_tick = 1'b0;
    period_edge = 1'b0;
    s_d.upd = 1'b0;

    // pin inputs, two stage sync
    s_d.hst_s = {s_q.hst_s[0], hyst_comp_in};
    s_d.cl_s  = {s_q.cl_s[0], cur_ref_comp_in};
    s_d.dr_s  = {s_q.dr_s[0], d_raw_in};
    // both current sources are pins, so they are synchronised before the mux
    s_d.amp_s = {s_q.amp_s[0], amplifier_output_in};
    s_d.dci_s = {s_q.dci_s[0], direct_current_input_in};

    // ========================================================
    // register writes
    if (wr_in) begin
      case (addr_in)
        `MPF_OFS_DFILT:     s_d.dfilt = wdata_in;
        `MPF_OFS_REFCHOP:   s_d.refchop = {2'b00, wdata_in[5:0]};
        `MPF_OFS_PWMCTL:    s_d.pwmctl = wdata_in;
        `MPF_OFS_UPDPER:    s_d.updper = wdata_in;
        `MPF_OFS_PERIPHCTL: s_d.periph = wdata_in;
        default: ;
      endcase
    end

    s_d.rdata = 8'h00;
    if (rd_in) begin
      case (addr_in)
        `MPF_OFS_DFILT:     s_d.rdata = s_q.dfilt;
        `MPF_OFS_REFCHOP:   s_d.rdata = {s_q.hst_s[1], s_q.cl_s[1], s_q.refchop[5:0]};
        `MPF_OFS_PWMCTL:    s_d.rdata = s_q.pwmctl;
        `MPF_OFS_UPDPER:    s_d.rdata = s_q.updper;
        `MPF_OFS_PERIPHCTL: s_d.rdata = s_q.periph;
        `MPF_OFS_STATUS:    s_d.rdata = {s_q.dev, s_q.pwm, s_q.rep_cnt[3:0]};
        default:            s_d.rdata = 8'h00;
      endcase
    end

    s_d.cur_sel = s_q.refchop[`MPF_REF_CSEL_BIT] ? s_q.dci_s[1] : s_q.amp_s[1];

    // ========================================================
    // d event filter
    // sampling tick from selectable divider
    if (s_q.scf_div == 8'h00) begin
      sample_tick = 1'b1;
      s_d.scf_div = {5'h00, s_q.periph[4:2]};
    end else begin
      s_d.scf_div = s_q.scf_div - 8'h01;
    end
    if (!s_q.dfilt[3]) begin
      blank_len = 14'(({11'h000, s_q.dfilt[2:0]} + 14'h0001) * `MPF_BLANK_FINE_CYC);
    end else begin
      blank_len = 14'(({11'h000, s_q.dfilt[2:0]} + 14'h0003) * `MPF_BLANK_COARSE_CYC);
    end
    if (c_event_in && !s_q.periph[`MPF_CTL_SENS_BIT]) begin
      s_d.blank = blank_len;
      s_d.dcnt = 5'h00;
      s_d.dev = 1'b0;
    end else if (s_q.blank != 14'h0000) begin
      s_d.blank = s_q.blank - 14'h0001;
    end else if (sample_tick) begin
      if (!s_q.dr_s[1]) begin
        s_d.dcnt = 5'h00;
        s_d.dev = 1'b0;
      end else if (s_q.dcnt > {1'b0, s_q.dfilt[7:4]}) begin
        s_d.dev = 1'b1;
      end else begin
        s_d.dcnt = s_q.dcnt + 5'h01;
        s_d.dev = (s_q.dcnt == {1'b0, s_q.dfilt[7:4]});
      end
    end

    // ========================================================
    // chopper
    // equal half periods
    if (s_q.chop_div == 8'h00) begin
      s_d.chop_div = chop_half(s_q.refchop[2:0]) - 8'h01;
      s_d.chop_ph = ~s_q.chop_ph;
    end else begin
      s_d.chop_div = s_q.chop_div - 8'h01;
    end
    case (mpf_pkg::mpf_chop_t'(s_q.refchop[4:3]))
      mpf_pkg::MPF_CHOP_LOW: begin
        s_d.chh = 1'b0;
        s_d.chl = s_q.chop_ph;
      end
      mpf_pkg::MPF_CHOP_HIGH: begin
        s_d.chh = s_q.chop_ph;
        s_d.chl = 1'b0;
      end
      mpf_pkg::MPF_CHOP_BOTH: begin
        s_d.chh = s_q.chop_ph;
        s_d.chl = s_q.chop_ph;
      end
      default: begin
        s_d.chh = 1'b0;
        s_d.chl = 1'b0;
      end
    endcase

    // ========================================================
    // pwm counter, held while peripheral clock disabled
    if (s_q.periph[`MPF_CTL_CKE_BIT]) begin
      if (s_q.pre >= s_q.pwmctl[2:0]) begin
        s_d.pre = 3'h0;
        cnt_tick = 1'b1;
      end else begin
        s_d.pre = s_q.pre + 3'h1;
      end
    end
    if (cnt_tick) begin
      if (!s_q.pwmctl[`MPF_PWM_CMS_BIT]) begin
        s_d.dir = mpf_pkg::MPF_CNT_UP;
        if (s_q.cnt == `MPF_PWM_TOP) begin
          s_d.cnt = 13'h0000;
          period_edge = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 13'h0001;
        end
      end else if (s_q.dir == mpf_pkg::MPF_CNT_UP) begin
        if (s_q.cnt == `MPF_PWM_TOP) begin
          s_d.dir = mpf_pkg::MPF_CNT_DOWN;
          period_edge = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 13'h0001;
        end
      end else begin
        if (s_q.cnt == 13'h0000) begin
          s_d.dir = mpf_pkg::MPF_CNT_UP;
          period_edge = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 13'h0001;
        end
      end
    end

    // enable rising forces load and update
    if (wr_in && addr_in == `MPF_OFS_PERIPHCTL && wdata_in[`MPF_CTL_CKE_BIT]
        && !s_q.periph[`MPF_CTL_CKE_BIT]) begin
      s_d.rep_act = s_q.updper;
      s_d.rep_cnt = s_q.updper;
      s_d.upd = 1'b1;
    end else if (period_edge) begin
      // count n+1 periods or half periods
      if (s_q.rep_cnt == 8'h00) begin
        s_d.upd = 1'b1;
        s_d.rep_act = s_q.updper;
        s_d.rep_cnt = s_q.updper;
      end else begin
        s_d.rep_cnt = s_q.rep_cnt - 8'h01;
      end
    end

    if (s_d.upd) begin
      s_d.full_act = s_d.pwmctl[6:4];
      s_d.pwmctl[6:4] = 3'b000;
      s_d.cmp_act = {cmp_of(phase_compare_u_in[15:3], s_q.pwmctl[7], s_q.pwmctl[`MPF_PWM_FDU_BIT]),
                     cmp_of(phase_compare_v_in[15:3], s_q.pwmctl[7], s_q.pwmctl[`MPF_PWM_FDV_BIT]),
                     cmp_of(phase_compare_w_in[15:3], s_q.pwmctl[7], s_q.pwmctl[`MPF_PWM_FDW_BIT])};
    end

    cmp_u = s_q.cmp_act[38:26];
    cmp_v = s_q.cmp_act[25:13];
    cmp_w = s_q.cmp_act[12:0];
    s_d.pwm[2] = s_q.full_act[2] | (s_q.cnt < cmp_u);
    s_d.pwm[1] = s_q.full_act[1] | (s_q.cnt < cmp_v);
    s_d.pwm[0] = s_q.full_act[0] | (s_q.cnt < cmp_w);
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      s_q <= '0;
      s_q.dfilt <= `MPF_RST_DFILT;
      s_q.refchop <= `MPF_RST_REFCHOP;
      s_q.pwmctl <= `MPF_RST_PWMCTL;
      s_q.updper <= `MPF_RST_UPDPER;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_out = s_q.rdata;
  assign d_event_out = s_q.dev;
  assign cur_comp_in_out = s_q.cur_sel;
  assign chop_high_out = s_q.chh;
  assign chop_low_out = s_q.chl;
  assign pwm_out = s_q.pwm;
  assign update_out = s_q.upd;

endmodule

`default_nettype wire

// ---- testbench/mpf_core_asserts.sv ----
// port checker for mpf_core
// assumes the bind below and the map in mpf_map.svh
`timescale 1ns/1ps
`include "mpf_map.svh"
`default_nettype none
module mpf_core_chk (
  input wire logic       core_clk_in,
  input wire logic       arst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       d_raw_in,
  input wire logic       hyst_comp_in,
  input wire logic       amplifier_output_in,
  input wire logic       direct_current_input_in,
  input wire logic       d_event_out,
  input wire logic       cur_comp_in_out,
  input wire logic       chop_high_out,
  input wire logic       chop_low_out,
  input wire logic       update_out
);
  // ==========================================================
  // shadow of written fields
  logic [7:0] filt_q;
  logic [7:0] per_q;
  logic [2:0] ref_q;
  logic       cke_q;
  logic [7:0] rb;
  assign rb = addr_in[0] ? per_q : filt_q;
  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      filt_q <= `MPF_RST_DFILT;
      per_q <= `MPF_RST_UPDPER;
      ref_q <= 3'h0;
      cke_q <= 1'b0;
    end else if (wr_in) begin
      if (addr_in == `MPF_OFS_DFILT) filt_q <= wdata_in;
      if (addr_in == `MPF_OFS_UPDPER) per_q <= wdata_in;
      if (addr_in == `MPF_OFS_REFCHOP) ref_q <= wdata_in[5:3];
      if (addr_in == `MPF_OFS_PERIPHCTL) cke_q <= wdata_in[0];
    end
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);
  // ==========================================================
  // steps and checks
  // worst case: sync, one slow sampling tick, output flop
  sequence raw_low_s;
    (!d_raw_in) [*8] ##1 (!d_raw_in) [*4];
  endsequence
  sequence en_rise_s;
    wr_in && addr_in == `MPF_OFS_PERIPHCTL && wdata_in[0] && !cke_q;
  endsequence
  sequence stat_rd_s;
    $stable(hyst_comp_in) [*4] ##0 (rd_in && addr_in == `MPF_OFS_REFCHOP);
  endsequence
  reg_readback_a: assert property (rd_in && (addr_in == 4'h0 || addr_in == 4'h3)
    |=> rdata_out == $past(rb)) else $error("readback wrong");
  hyst_status_a: assert property (stat_rd_s |=> rdata_out[7] == $past(hyst_comp_in))
    else $error("hyst bit wrong");
  // two sync stages plus the output flop
  cur_route_a: assert property ($past(arst_n_in, 3) |-> cur_comp_in_out ==
    ($past(ref_q[2]) ? $past(direct_current_input_in, 3) : $past(amplifier_output_in, 3)))
    else $error("route wrong");
  en_update_a: assert property (en_rise_s |=> update_out)
    else $error("no enable update");
  upd_pulse_a: assert property (update_out |=> !update_out)
    else $error("update too long");
  d_drop_a: assert property (raw_low_s |-> !d_event_out)
    else $error("d event held");
  chop_high_a: assert property (!ref_q[1] && !$past(ref_q[1]) |-> !chop_high_out)
    else $error("high chop on");
  chop_low_a: assert property (!ref_q[0] && !$past(ref_q[0]) |-> !chop_low_out)
    else $error("low chop on");
endmodule
bind mpf_core mpf_core_chk mpf_core_chk_inst (.core_clk_in, .arst_n_in, .addr_in, .wdata_in, .wr_in,
  .rd_in, .rdata_out, .d_raw_in, .hyst_comp_in, .amplifier_output_in, .direct_current_input_in,
  .d_event_out, .cur_comp_in_out, .chop_high_out, .chop_low_out, .update_out);
`default_nettype wire

// ---- testbench/mpf_stage.sv ----
// power stage and comparator model
// assumes LAG of two or more; bench sets levels on the core clock
`timescale 1ns/1ps
`default_nettype none
module mpf_stage #(parameter int LAG = 2) (
  input  wire logic       core_clk_in,
  input  wire logic [4:0] lvl_in,
  output logic      [4:0] lvl_out
);
  // comparators settle late, so levels trail the request
  logic [5*LAG-1:0] dly_q = '0;
  always @(posedge core_clk_in) dly_q <= {dly_q[5*LAG-6:0], lvl_in};
  assign lvl_out = dly_q[5*LAG-1 -: 5];
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// bench for mpf_core: registers, routing, update pacing, chopper, d filter
// assumes mpf_stage feeds the comparator pins; bench owns bus and c events
`timescale 1ns/1ps
`include "mpf_map.svh"
`default_nettype none
module tb;
  logic       core_clk_in = 1'b0;
  logic       arst_n_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'b0;
  logic       rd_in = 1'b0;
  logic       c_event_in = 1'b0;
  logic [4:0] lvl = 5'h00;
  logic [4:0] pin;
  logic [15:0] cmp_u = 16'h0000;
  logic [7:0] rdata_out;
  logic [2:0] pwm_out;
  logic       d_event_out, cur_comp_in_out, chop_high_out, chop_low_out, update_out;
  int         miscompares = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         d_hits = 0;
  int         t_upd[$];
  always #12.5 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) begin
    cyc++;
    if (update_out === 1'b1) t_upd.push_back(cyc);
    if (d_event_out === 1'b1) d_hits++;
  end
  mpf_stage #(.LAG(3)) mpf_stage_inst (.core_clk_in, .lvl_in(lvl), .lvl_out(pin));
  mpf_core mpf_core_inst (.core_clk_in, .arst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .phase_compare_u_in(cmp_u), .phase_compare_v_in(16'h0000), .phase_compare_w_in(16'h0000),
    .d_raw_in(pin[4]), .c_event_in, .hyst_comp_in(pin[3]), .cur_ref_comp_in(pin[2]),
    .amplifier_output_in(pin[1]), .direct_current_input_in(pin[0]), .d_event_out, .cur_comp_in_out,
    .chop_high_out, .chop_low_out, .pwm_out, .update_out);
  // ==========================================================
  // bus and compare tasks
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge core_clk_in);
    wr_in <= 1'b0;
    @(posedge core_clk_in);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge core_clk_in);
    rd_in <= 1'b0;
    @(negedge core_clk_in);
    chk(n, 16'(e), 16'(rdata_out));
    @(posedge core_clk_in);
  endtask
  task automatic wait_upd(input int k);
    for (int i = 0; i < 40000 && t_upd.size() < k; i++) @(posedge core_clk_in);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rd(`MPF_OFS_DFILT, `MPF_RST_DFILT, "dfilt rst");
    rd(`MPF_OFS_PWMCTL, `MPF_RST_PWMCTL, "pwmctl rst");
    rd(`MPF_OFS_UPDPER, `MPF_RST_UPDPER, "updper rst");
    lvl <= 5'h08;
    wr(4'hf, 8'h5a);
    rd(4'hf, 8'h00, "unmapped");
    wr(`MPF_OFS_DFILT, 8'ha5);
    rd(`MPF_OFS_DFILT, 8'ha5, "dfilt rw");
    wr(`MPF_OFS_REFCHOP, 8'hff);
    rd(`MPF_OFS_REFCHOP, 8'hbf, "refchop");
    lvl <= 5'h04;
    repeat (8) @(posedge core_clk_in);
    rd(`MPF_OFS_REFCHOP, 8'h7f, "cl status");
  endtask
  task automatic t_update();
    wr(`MPF_OFS_PERIPHCTL, 8'h01);
    // let the update pulse be logged before looking
    @(posedge core_clk_in);
    chk("enable upd", 16'h1, 16'(t_upd.size()));
    wr(`MPF_OFS_UPDPER, 8'h01);
    wait_upd(2);
    chk("rep pending", 16'd8192, 16'(t_upd[1] - t_upd[0]));
    wr(`MPF_OFS_PWMCTL, 8'h40);
    wait_upd(3);
    chk("n+1 periods", 16'd16384, 16'(t_upd[2] - t_upd[1]));
    repeat (100) @(posedge core_clk_in);
    chk("full duty u", 16'h1, 16'(pwm_out[2]));
    rd(`MPF_OFS_PWMCTL, 8'h00, "full duty clr");
    // compare 4096: center mode is high near the low turn only
    cmp_u <= 16'h8000;
    wr(`MPF_OFS_UPDPER, 8'h00);
    wr(`MPF_OFS_PWMCTL, 8'h08);
    wait_upd(4);
    repeat (100) @(posedge core_clk_in);
    chk("center low turn", 16'h1, 16'(pwm_out[2]));
    wait_upd(5);
    chk("center half", 16'd8192, 16'(t_upd[4] - t_upd[3]));
    repeat (100) @(posedge core_clk_in);
    chk("center top turn", 16'h0, 16'(pwm_out[2]));
    wr(`MPF_OFS_PWMCTL, 8'h01);
    wait_upd(7);
    chk("prescale 2", 16'd16384, 16'(t_upd[6] - t_upd[5]));
  endtask
  task automatic t_route();
    for (int k = 0; k < 8; k++) begin
      wr(`MPF_OFS_REFCHOP, {2'h0, k[2], 5'h00});
      lvl <= {3'h0, k[1:0]};
      repeat (8) @(posedge core_clk_in);
      chk("cur route", 16'(k[2] ? k[0] : k[1]), 16'(cur_comp_in_out));
    end
  endtask
  task automatic t_chop();
    int hh;
    int hl;
    for (int m = 0; m < 4; m++) begin
      wr(`MPF_OFS_REFCHOP, {3'h0, m[1:0], 3'h7});
      repeat (40) @(posedge core_clk_in);
      hh = 0;
      hl = 0;
      repeat (200) begin
        @(negedge core_clk_in);
        hh += (chop_high_out === 1'b1);
        hl += (chop_low_out === 1'b1);
      end
      @(posedge core_clk_in);
      chk("chop high", 16'(m[1] ? 100 : 0), 16'(hh));
      chk("chop low", 16'(m[0] ? 100 : 0), 16'(hl));
    end
  endtask
  task automatic t_dfilt();
    int h0;
    wr(`MPF_OFS_PERIPHCTL, 8'h03);
    wr(`MPF_OFS_DFILT, 8'h30);
    h0 = d_hits;
    repeat (3) begin
      lvl <= 5'h10;
      repeat (3) @(posedge core_clk_in);
      lvl <= 5'h00;
      @(posedge core_clk_in);
    end
    repeat (6) @(posedge core_clk_in);
    chk("broken run", 16'(h0), 16'(d_hits));
    lvl <= 5'h10;
    repeat (6) @(posedge core_clk_in);
    chk("d early", 16'h0, 16'(d_event_out));
    repeat (9) @(posedge core_clk_in);
    chk("d filtered", 16'h1, 16'(d_event_out));
    wr(`MPF_OFS_DFILT, 8'h00);
    for (int s = 0; s < 2; s++) begin
      lvl <= 5'h00;
      wr(`MPF_OFS_PERIPHCTL, {6'h00, s[0], 1'b1});
      repeat (20) @(posedge core_clk_in);
      c_event_in <= 1'b1;
      lvl <= 5'h10;
      @(posedge core_clk_in);
      c_event_in <= 1'b0;
      repeat (30) @(posedge core_clk_in);
      chk("blank", 16'(s), 16'(d_event_out));
      repeat (220) @(posedge core_clk_in);
      chk("after blank", 16'h1, 16'(d_event_out));
    end
    // sampling tick every eighth clock, four samples needed
    lvl <= 5'h00;
    wr(`MPF_OFS_PERIPHCTL, 8'h1f);
    wr(`MPF_OFS_DFILT, 8'h30);
    repeat (20) @(posedge core_clk_in);
    lvl <= 5'h10;
    repeat (20) @(posedge core_clk_in);
    chk("slow early", 16'h0, 16'(d_event_out));
    repeat (30) @(posedge core_clk_in);
    chk("slow filtered", 16'h1, 16'(d_event_out));
  endtask
  task automatic test_done();
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk_in);
    arst_n_in <= 1'b1;
    t_regs();
    t_update();
    t_route();
    t_chop();
    t_dfilt();
    test_done();
  end
  // about 70k cycles expected
  initial begin
    repeat (90000) @(posedge core_clk_in);
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
